/* File: hw/adcts_defines.vh */
// constants for the converter trigger-select block
// assumes inclusion by bare name from the design files under hw/
`ifndef ADCTS_DEFINES_VH
`define ADCTS_DEFINES_VH

// register offsets (byte addresses, one word each)
`define ADCTS_OFS_SELECT   8'h00
`define ADCTS_OFS_SWSTART  8'h04
`define ADCTS_OFS_STATUS   8'h08
`define ADCTS_OFS_COUNT    8'h0C

// select register fields
`define ADCTS_SEQ0_LSB     0
`define ADCTS_SEQ0_MSB     3
`define ADCTS_SEQ1_LSB     4
`define ADCTS_SEQ1_MSB     7
`define ADCTS_SELECT_RST   8'h00

// status register fields
`define ADCTS_ST_START_LSB 0
`define ADCTS_ST_RSVD_LSB  2
`define ADCTS_ST_PIN_BIT   4
`define ADCTS_STATUS_RST   2'h0

// count register fields
`define ADCTS_CNT0_LSB     0
`define ADCTS_CNT1_LSB     8
`define ADCTS_COUNT_RST    8'h00

// trigger select codes
`define ADCTS_CODE_SW      4'h0
`define ADCTS_CODE_COMP0   4'h1
`define ADCTS_CODE_EXT     4'h4
`define ADCTS_CODE_TIMER   4'h5
`define ADCTS_CODE_PWM0    4'h6
`define ADCTS_CODE_PWM1    4'h7
`define ADCTS_CODE_PWM2    4'h8
`define ADCTS_CODE_ALWAYS  4'hF

`endif

/* File: hw/adcts_trig_mux.v */
// one sequencer's trigger multiplexer with its registered start pulse
// assumes all event inputs are one-cycle pulses already in the clock domain
`timescale 1ns/10ps
`include "adcts_defines.vh"

module adcts_trig_mux (
  input  wire       clock,     // converter clock
  input  wire       rst_n,     // synchronised reset, active low
  input  wire       clock_en,  // freezes state while low
  input  wire [3:0] sel,       // trigger select code
  input  wire       sw_evt,    // software start request
  input  wire       comp_evt,  // comparator 0 event
  input  wire       ext_evt,   // external pin edge
  input  wire       tmr_evt,   // gated timer event
  input  wire [2:0] pwm_evt,   // pwm generator events
  output reg        start_reg, // start pulse to the sequencer
  output reg        rsvd_reg   // select holds a reserved code
);

  reg hit_next;
  reg rsvd_next;

  // ----------------------------------------------------------------
  // source decode
  // ----------------------------------------------------------------
  always @* begin
    hit_next  = 1'b0;
    rsvd_next = 1'b0;
    case (sel)
      `ADCTS_CODE_SW:     hit_next = sw_evt;
      `ADCTS_CODE_COMP0:  hit_next = comp_evt;
      `ADCTS_CODE_EXT:    hit_next = ext_evt;
      `ADCTS_CODE_TIMER:  hit_next = tmr_evt;
      `ADCTS_CODE_PWM0:   hit_next = pwm_evt[0];
      `ADCTS_CODE_PWM1:   hit_next = pwm_evt[1];
      `ADCTS_CODE_PWM2:   hit_next = pwm_evt[2];
      // the sequencer restarts every cycle it is ready to take one
      `ADCTS_CODE_ALWAYS: hit_next = 1'b1;
      // reserved codes never start anything, only flag themselves
      default:            rsvd_next = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // registered start
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
      rsvd_reg  <= 1'b0;
    end else if (clock_en) begin
      start_reg <= hit_next;
      rsvd_reg  <= rsvd_next;
    end
  end

endmodule

/* File: hw/adcts_top.v */
// trigger-source selection for sample sequencers 0 and 1
// assumes comparator, timer and pwm events come from logic on clock;
// the external trigger pin is asynchronous and is synchronised here
//
// Functional notes
// - sequencer 1 select at bits 7:4, read/write, resets to software trigger 0x0.
// - sequencer 0 select at bits 3:0, read/write, resets to software trigger 0x0.
// - code 0x1 starts the sequencer on an analog comparator 0 event.
// - code 0x4 starts the sequencer on an external trigger pin event.
// - code 0x5 uses the timer event, only when timer output-trigger enable is set.
// - codes 0x6, 0x7, 0x8 use pwm generator 0, 1, 2 trigger outputs.
// - code 0xF samples continuously; 0x2, 0x3, 0x9-0xE reserved, software avoids them.
`timescale 1ns/10ps
`include "adcts_defines.vh"

module adcts_top (
  input  wire        clock,            // 25 MHz converter clock
  input  wire        arst_n,           // asynchronous reset, active low
  input  wire        clock_en,         // freezes all state but the reset synchroniser while low
  input  wire [7:0]  reg_addr,         // register byte address
  input  wire [31:0] reg_wdata,        // register write data
  input  wire        reg_wr,           // write strobe
  input  wire        reg_rd,           // read strobe
  output reg  [31:0] reg_rdata,        // read data, cycle after reg_rd
  input  wire        comp0_evt,        // comparator 0 trigger level
  input  wire        external_trigger_pin, // asynchronous trigger pin
  input  wire        timer_evt,        // timer trigger level
  input  wire        timer_out_trig_en, // timer output-trigger enable
  input  wire [2:0]  pwm_trig,         // pwm generator 0..2 trigger levels
  output wire        seq0_start,       // start pulse, sample_sequencer_0
  output wire        seq1_start        // start pulse, sample_sequencer_1
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_n_reg;

  // assertion is immediate, release waits two edges to stay clean
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // external pin synchroniser
  // ----------------------------------------------------------------
  reg pin_s1_reg;
  reg pin_s2_reg;
  reg pin_s3_reg;
  reg pin_lvl_reg;
  reg pin_edge_reg;

  // a change counts only once stages two and three agree
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_s3_reg   <= 1'b0;
      pin_lvl_reg  <= 1'b0;
      pin_edge_reg <= 1'b0;
    end else if (clock_en) begin
      pin_s1_reg   <= external_trigger_pin;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      if (pin_s2_reg == pin_s3_reg) begin
        pin_lvl_reg <= pin_s3_reg;
      end
      pin_edge_reg <= (pin_s2_reg == pin_s3_reg) && pin_s3_reg && !pin_lvl_reg;
    end
  end

  // ----------------------------------------------------------------
  // on-chip event edges
  // ----------------------------------------------------------------
  reg       comp_d_reg;
  reg       tmr_d_reg;
  reg [2:0] pwm_d_reg;
  wire       comp_edge;
  wire       tmr_edge;
  wire [2:0] pwm_edge;

  // levels held for several cycles must start a sequencer only once
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      comp_d_reg <= 1'b0;
      tmr_d_reg  <= 1'b0;
      pwm_d_reg  <= 3'h0;
    end else if (clock_en) begin
      comp_d_reg <= comp0_evt;
      tmr_d_reg  <= timer_evt & timer_out_trig_en;
      pwm_d_reg  <= pwm_trig;
    end
  end

  assign comp_edge = comp0_evt & ~comp_d_reg;
  assign tmr_edge  = timer_evt & timer_out_trig_en & ~tmr_d_reg;
  assign pwm_edge  = pwm_trig & ~pwm_d_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0] select_reg;
  reg  [1:0] sw_req_reg;
  reg  [1:0] started_reg;
  reg  [7:0] count0_reg;
  reg  [7:0] count1_reg;
  reg  [1:0] started_next;
  wire       wr_select;
  wire       wr_swstart;
  wire       wr_status;
  wire       wr_count;
  wire       rsvd0;
  wire       rsvd1;

  assign wr_select  = reg_wr && (reg_addr == `ADCTS_OFS_SELECT);
  assign wr_swstart = reg_wr && (reg_addr == `ADCTS_OFS_SWSTART);
  assign wr_status  = reg_wr && (reg_addr == `ADCTS_OFS_STATUS);
  assign wr_count   = reg_wr && (reg_addr == `ADCTS_OFS_COUNT);

  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      select_reg <= `ADCTS_SELECT_RST;
    end else if (clock_en && wr_select) begin
      select_reg <= reg_wdata[7:0];
    end
  end

  // software requests are one-cycle; the mux decides if they count
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sw_req_reg <= 2'h0;
    end else if (clock_en) begin
      sw_req_reg <= wr_swstart ? reg_wdata[1:0] : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // start status, write one to clear; a start in the same cycle wins
  // ----------------------------------------------------------------
  always @* begin
    started_next = started_reg;
    if (wr_status) begin
      started_next = started_reg & ~reg_wdata[1:0];
    end
    started_next = started_next | {seq1_start, seq0_start};
  end

  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      started_reg <= `ADCTS_STATUS_RST;
    end else if (clock_en) begin
      started_reg <= started_next;
    end
  end

  // wrapping start counters; a write clears both
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      count0_reg <= `ADCTS_COUNT_RST;
      count1_reg <= `ADCTS_COUNT_RST;
    end else if (clock_en) begin
      if (wr_count) begin
        count0_reg <= `ADCTS_COUNT_RST;
        count1_reg <= `ADCTS_COUNT_RST;
      end else begin
        if (seq0_start) begin
          count0_reg <= count0_reg + 8'h01;
        end
        if (seq1_start) begin
          count1_reg <= count1_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger multiplexers
  // ----------------------------------------------------------------
  adcts_trig_mux u_mux0 (
    .clock     (clock),
    .rst_n     (rst_n_reg),
    .clock_en  (clock_en),
    .sel       (select_reg[`ADCTS_SEQ0_MSB:`ADCTS_SEQ0_LSB]),
    .sw_evt    (sw_req_reg[0]),
    .comp_evt  (comp_edge),
    .ext_evt   (pin_edge_reg),
    .tmr_evt   (tmr_edge),
    .pwm_evt   (pwm_edge),
    .start_reg (seq0_start),
    .rsvd_reg  (rsvd0)
  );

  adcts_trig_mux u_mux1 (
    .clock     (clock),
    .rst_n     (rst_n_reg),
    .clock_en  (clock_en),
    .sel       (select_reg[`ADCTS_SEQ1_MSB:`ADCTS_SEQ1_LSB]),
    .sw_evt    (sw_req_reg[1]),
    .comp_evt  (comp_edge),
    .ext_evt   (pin_edge_reg),
    .tmr_evt   (tmr_edge),
    .pwm_evt   (pwm_edge),
    .start_reg (seq1_start),
    .rsvd_reg  (rsvd1)
  );

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `ADCTS_OFS_SELECT: begin
          rdata_next[7:0] = select_reg;
        end
        `ADCTS_OFS_STATUS: begin
          rdata_next[`ADCTS_ST_START_LSB+1:`ADCTS_ST_START_LSB] = started_reg;
          rdata_next[`ADCTS_ST_RSVD_LSB+1:`ADCTS_ST_RSVD_LSB]   = {rsvd1, rsvd0};
          rdata_next[`ADCTS_ST_PIN_BIT]                         = pin_lvl_reg;
        end
        `ADCTS_OFS_COUNT: begin
          rdata_next[`ADCTS_CNT0_LSB+7:`ADCTS_CNT0_LSB] = count0_reg;
          rdata_next[`ADCTS_CNT1_LSB+7:`ADCTS_CNT1_LSB] = count1_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clock_en) begin
      reg_rdata <= rdata_next;
    end
  end

endmodule

/* File: tb/adcts_top_sva.sv */
// assertions on the ports of the trigger-select block
// assumes the register map and latencies of the hand-over; bound below
`timescale 1ns/10ps
module adcts_top_sva (
  input logic        clock,                // clock
  input logic        arst_n,               // reset, active low
  input logic        clock_en,             // run enable
  input logic [7:0]  reg_addr,             // address
  input logic [31:0] reg_wdata,            // write data
  input logic        reg_wr,               // write strobe
  input logic        reg_rd,               // read strobe
  input logic [31:0] reg_rdata,            // read data
  input logic        comp0_evt,            // comparator
  input logic        external_trigger_pin, // pin
  input logic        timer_evt,            // timer
  input logic        timer_out_trig_en,    // timer gate
  input logic [2:0]  pwm_trig,             // pwm levels
  input logic        seq0_start,           // start 0
  input logic        seq1_start            // start 1
);
  reg  [7:0] sel_reg;
  reg  [4:0] prv_reg;
  wire [4:0] rise = {pwm_trig, timer_evt, comp0_evt} & ~prv_reg;
  // shadow select, so the checker never trusts the design's own copy
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= 8'h00;
      prv_reg <= 5'h00;
    end else if (clock_en) begin
      if (reg_wr && reg_addr == 8'h00) sel_reg <= reg_wdata[7:0];
      prv_reg <= {pwm_trig, timer_evt, comp0_evt};
    end
  end
  function automatic logic hit(input logic [3:0] c, input logic [4:0] r, input logic e);
    hit = (c == 4'h1 && r[0]) || (c == 4'h5 && r[1] && e) || (c > 4'h5 && c < 4'h9 && r[c - 4'h4]);
  endfunction
  function automatic logic rsvd(input logic [3:0] c);
    rsvd = c == 4'h2 || c == 4'h3 || (c > 4'h8 && c < 4'hF);
  endfunction
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_sw0;
    clock_en && reg_wr && reg_addr == 8'h04 && reg_wdata[0] && sel_reg[3:0] == 4'h0;
  endsequence
  sequence s_pin0;
    sel_reg[3:0] == 4'h4 && $rose(external_trigger_pin);
  endsequence
  a_rdata_idle:
    assert property (clock_en && !reg_rd |=> reg_rdata == 32'h0) else $error("stray read data");
  a_select_back:
    assert property (clock_en && reg_rd && reg_addr == 8'h00
      |=> reg_rdata == {24'h0, $past(sel_reg)})
    else $error("select readback wrong");
  a_sw_start:
    assert property (s_sw0 |-> ##2 seq0_start) else $error("software start missing");
  a_event_seq0:
    assert property (clock_en && hit(sel_reg[3:0], rise, timer_out_trig_en) |-> ##[1:2] seq0_start)
    else $error("event start missing on 0");
  a_event_seq1:
    assert property (clock_en && hit(sel_reg[7:4], rise, timer_out_trig_en) |-> ##[1:2] seq1_start)
    else $error("event start missing on 1");
  a_pin_start:
    assert property (s_pin0 |-> ##[3:8] seq0_start) else $error("pin start missing");
  a_timer_gate:
    assert property ((sel_reg[3:0] == 4'h5 && !timer_out_trig_en)[*3] |=> !seq0_start)
    else $error("gated timer started");
  a_always_on:
    assert property (clock_en && sel_reg[3:0] == 4'hF |=> seq0_start)
    else $error("not continuous");
  a_rsvd_quiet:
    assert property (clock_en && rsvd(sel_reg[3:0]) |=> !seq0_start)
    else $error("reserved started");
  a_one_pulse:
    assert property (seq0_start && clock_en && $stable(sel_reg) && sel_reg[3:0] != 4'hF
      |=> !seq0_start) else $error("start longer than one cycle");
endmodule
bind adcts_top adcts_top_sva u_sva (.clock, .arst_n, .clock_en, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .comp0_evt, .external_trigger_pin, .timer_evt, .timer_out_trig_en,
  .pwm_trig, .seq0_start, .seq1_start);

/* File: tb/adcts_src_model.sv */
// event sources beside the converter: comparator, timer, pwm, pin
// assumes the bench calls one task at a time
`timescale 1ns/10ps
module adcts_src_model (
  input  logic       clock,                // converter clock
  output logic       comp0_evt,            // comparator level
  output logic       timer_evt,            // timer level
  output logic       timer_out_trig_en,    // timer gate
  output logic [2:0] pwm_trig,             // pwm levels
  output logic       external_trigger_pin  // async pin
);
  logic [4:0] lv_reg = 5'h00;
  assign comp0_evt = lv_reg[0];
  assign timer_evt = lv_reg[1];
  assign pwm_trig  = lv_reg[4:2];
  initial begin
    timer_out_trig_en = 1'b0;
    external_trigger_pin = 1'b0;
  end
  // without the gate, timer events never reach the converter
  task automatic set_en(input logic e);
    @(posedge clock);
    timer_out_trig_en <= e;
  endtask
  // levels stay up 8 cycles so each event is one clean edge
  task automatic fire(input int s);
    @(posedge clock);
    if (s == 5) #7 external_trigger_pin = 1'b1;
    else lv_reg[s] <= 1'b1;
    repeat (8) @(posedge clock);
    if (s == 5) #7 external_trigger_pin = 1'b0;
    else lv_reg[s] <= 1'b0;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the trigger-select block
// assumes the source model and the bound checker
`timescale 1ns/10ps
module testbench;
  logic        clock;
  logic        arst_n;
  logic        clock_en;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  wire  [31:0] reg_rdata;
  wire         comp0_evt;
  wire         timer_evt;
  wire         timer_out_trig_en;
  wire  [2:0]  pwm_trig;
  wire         external_trigger_pin;
  wire         seq0_start;
  wire         seq1_start;
  int          n_fail = 0;
  int          checks = 0;
  int          cnt0;
  int          cnt1;
  adcts_top uut (.clock, .arst_n, .clock_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .comp0_evt, .external_trigger_pin, .timer_evt, .timer_out_trig_en,
    .pwm_trig, .seq0_start, .seq1_start);
  adcts_src_model src (.clock, .comp0_evt, .timer_evt, .timer_out_trig_en, .pwm_trig,
    .external_trigger_pin);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic finish_test;
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic count_win;
    repeat (20) begin
      @(posedge clock);
      cnt0 += (seq0_start === 1'b1);
      cnt1 += (seq1_start === 1'b1);
    end
  endtask
  // starts expected in a 20-cycle window; source 6 is the software request
  function automatic int exp_n(input logic [3:0] c, input int s, input logic en);
    if (c == 4'hF) return 20;
    case (s)
      0: return c == 4'h1;
      1: return c == 4'h5 && en;
      5: return c == 4'h4;
      6: return c == 4'h0;
      default: return c == 4'h4 + s;
    endcase
  endfunction
  initial begin
    #1_000_000;
    n_fail++;
    finish_test;
  end
  initial begin : main
    logic [31:0] d;
    logic [7:0]  sel;
    logic        en;
    arst_n = 1'b0;
    clock_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    void'($urandom(32'h221bfc65));
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h00, d);
    check(d, 32'h0);
    // code 5 runs twice: gate closed, then open
    for (int c = 0; c < 17; c++) begin
      sel = {4'($urandom), (c == 16) ? 4'h5 : 4'(c)};
      en = (c == 16) || (c != 5 && 1'($urandom));
      src.set_en(en);
      wr(8'h00, {24'h0, sel});
      rd(8'h00, d);
      check(d, {24'h0, sel});
      for (int s = 0; s < 7; s++) begin
        cnt0 = 0;
        cnt1 = 0;
        fork
          count_win();
          if (s == 6) wr(8'h04, 32'h3);
          else src.fire(s);
        join
        check(cnt0, exp_n(sel[3:0], s, en));
        check(cnt1, exp_n(sel[7:4], s, en));
      end
    end
    // counters and sticky status: comparator start on 1, reserved code on 0
    sel = 8'h12;
    wr(8'h00, {24'h0, sel});
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h3);
    src.fire(0);
    rd(8'h0C, d);
    check(d, 32'h0000_0100);
    rd(8'h08, d);
    check(d, 32'h0000_0006);
    // both clears: counts to zero, only the reserved flag stays up
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h3);
    rd(8'h0C, d);
    check(d, 32'h0000_0000);
    rd(8'h08, d);
    check(d, 32'h0000_0004);
    rd(8'hFC, d);
    check(d, 32'h0);
    wr(8'hFC, 32'hA5);
    @(posedge clock) clock_en <= 1'b0;
    wr(8'h00, 32'h3C);
    @(posedge clock) clock_en <= 1'b1;
    rd(8'h00, d);
    check(d, {24'h0, sel});
    @(posedge clock) arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h00, d);
    check(d, 32'h0);
    finish_test;
  end
endmodule
